// [hw/lss_top.sv]
// Link start-up sequencer with APB registers and interrupt
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "lss_defs.svh"
module lss_top
#(
  parameter int unsigned PWR_HOLD_CYC = `LSS_PWR_HOLD_CYC,
  parameter int unsigned LOCK_CYC     = `LSS_LOCK_CYC
)
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [`LSS_ADDR_W-1:0]  i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  input  wire logic                    i_cfg_sig,
  input  wire logic                    i_ser_sig,
  input  wire lss_pkg::lss_fmt_t       i_rx_fmt,
  output lss_pkg::lss_fmt_t            o_fmt,
  output logic                         o_cc_avail,
  output logic                         o_cfg_lock,
  output logic                         o_lock,
  output logic                         o_data_en,
  output logic                         o_irq
);
  import lss_pkg::*;

  localparam int NLINK = 2;

  logic [4:0]            sync_q;
  logic                  cfg_sig;
  logic                  ser_sig;
  lss_fmt_t              rx_fmt;
  logic [NLINK-1:0]      qual;
  logic [NLINK-1:0]      lock;
  logic                  fmt_match;

  lss_state_t            state_r;
  lss_state_t            state_nxt;
  logic [`LSS_CNT_W-1:0] hold_r;
  logic [`LSS_CNT_W-1:0] hold_nxt;
  lss_fmt_t              fmt_r;
  lss_fmt_t              fmt_nxt;
  logic                  cc_r;
  logic                  cc_nxt;
  logic                  data_en_r;
  logic                  data_en_nxt;
  logic [NLINK-1:0]      lock_d_r;
  logic [`LSS_IRQ_W-1:0] irq_stat_r;
  logic [`LSS_IRQ_W-1:0] irq_stat_nxt;
  logic [`LSS_IRQ_W-1:0] irq_mask_r;
  logic [`LSS_IRQ_W-1:0] irq_mask_nxt;
  logic [`LSS_IRQ_W-1:0] irq_ev;
  logic [31:0]           prdata_r;
  logic [31:0]           prdata_nxt;
  logic                  pslverr_r;
  logic                  pslverr_nxt;
  logic                  loaded;
  logic                  setup;
  logic                  wr_en;

  function automatic logic addr_ok(input logic [`LSS_ADDR_W-1:0] a);
    addr_ok = (a == `LSS_OFF_CTRL) || (a == `LSS_OFF_STAT) ||
              (a == `LSS_OFF_IRQ_STAT) || (a == `LSS_OFF_IRQ_MASK);
  endfunction

  // Pin-side levels into the clock domain
  lss_sync #(.W(5)) u_sync
  (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   ({i_rx_fmt, i_ser_sig, i_cfg_sig}),
    .o_q   (sync_q)
  );

  assign cfg_sig = sync_q[0];
  assign ser_sig = sync_q[1];
  assign rx_fmt  = sync_q[4:2];

  // Rate mismatch keeps lock; width or protection mismatch loses it
  assign fmt_match = (fmt_r[`LSS_FMT_WIDTH] == rx_fmt[`LSS_FMT_WIDTH]) &&
                     (fmt_r[`LSS_FMT_PROT] == rx_fmt[`LSS_FMT_PROT]);

  assign loaded = (state_r != ST_LOAD);

  // Configuration link qualified only while no video signal
  assign qual[`LSS_LINK_CFG] = loaded && cfg_sig && !ser_sig &&
                               fmt_match;
  assign qual[`LSS_LINK_VID] = loaded && ser_sig &&
                               fmt_match;

  // Lock detectors for both links, timed by the local clock
  generate
    for (genvar g = 0; g < NLINK; g++)
    begin : g_link
      lss_lock_if lk ();
      assign lk.qual = qual[g];
      assign lock[g] = lk.lock;
      lss_lock_det #(.LOCK_CYC(LOCK_CYC)) u_det
      (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .lk    (lk)
      );
    end
  endgenerate

  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite && loaded;

  // Sequencer
  always_comb
  begin
    state_nxt = state_r;
    hold_nxt  = hold_r;
    fmt_nxt   = fmt_r;
    unique case (state_r)
      ST_LOAD:
      begin
        fmt_nxt = `LSS_FMT_DEFAULT;
        // Decide once the pin synchroniser holds real levels
        if (hold_r >= `LSS_CNT_W'(`LSS_SYNC_CYC))
        begin
          hold_nxt = '0;
          if (cfg_sig || ser_sig)
            state_nxt = ST_HOLD;
          else
            state_nxt = ST_NO_LINK;
        end
        else
          hold_nxt = hold_r + `LSS_CNT_W'(1);
      end
      ST_HOLD:
      begin
        if (hold_r >= `LSS_CNT_W'(PWR_HOLD_CYC - 1))
          state_nxt = ST_NO_LINK;
        else
          hold_nxt = hold_r + `LSS_CNT_W'(1);
      end
      ST_NO_LINK:
      begin
        if (lock[`LSS_LINK_VID])
          state_nxt = ST_VID_LINK;
        else if (lock[`LSS_LINK_CFG])
          state_nxt = ST_CFG_LINK;
      end
      ST_CFG_LINK:
      begin
        if (lock[`LSS_LINK_VID])
          state_nxt = ST_VID_LINK;
        else if (!lock[`LSS_LINK_CFG])
          state_nxt = ST_NO_LINK;
      end
      ST_VID_LINK:
      begin
        if (!lock[`LSS_LINK_VID])
          state_nxt = ST_NO_LINK;
      end
      default:
        state_nxt = ST_LOAD;
    endcase
    if (wr_en && (i_paddr == `LSS_OFF_CTRL))
      fmt_nxt = i_pwdata[2:0];
  end

  // Channel and data path gating
  always_comb
  begin
    cc_nxt      = (state_nxt == ST_CFG_LINK) ||
                  (state_nxt == ST_VID_LINK);
    data_en_nxt = (state_nxt == ST_VID_LINK);
  end

  // Interrupt status and mask
  always_comb
  begin
    irq_ev = '0;
    irq_ev[`LSS_IRQ_VID_LOCK]  = lock[`LSS_LINK_VID] &&
                                 !lock_d_r[`LSS_LINK_VID];
    irq_ev[`LSS_IRQ_LOCK_LOST] = |(lock_d_r & ~lock);
    irq_ev[`LSS_IRQ_CC_READY]  = cc_nxt && !cc_r;
    irq_stat_nxt = irq_stat_r;
    irq_mask_nxt = irq_mask_r;
    if (wr_en && (i_paddr == `LSS_OFF_IRQ_STAT))
      irq_stat_nxt = irq_stat_r & ~i_pwdata[`LSS_IRQ_W-1:0];
    if (wr_en && (i_paddr == `LSS_OFF_IRQ_MASK))
      irq_mask_nxt = i_pwdata[`LSS_IRQ_W-1:0];
    irq_stat_nxt = irq_stat_nxt | irq_ev;
  end

  // Read data captured in the setup cycle
  always_comb
  begin
    prdata_nxt  = prdata_r;
    pslverr_nxt = pslverr_r;
    if (setup)
    begin
      prdata_nxt  = '0;
      pslverr_nxt = !addr_ok(i_paddr);
      if (!i_pwrite)
      begin
        if (i_paddr == `LSS_OFF_CTRL)
          prdata_nxt[2:0] = fmt_r;
        else if (i_paddr == `LSS_OFF_STAT)
        begin
          prdata_nxt[2:0] = state_r;
          prdata_nxt[`LSS_STAT_CFG_LOCK] = lock[`LSS_LINK_CFG];
          prdata_nxt[`LSS_STAT_VID_LOCK] = lock[`LSS_LINK_VID];
          prdata_nxt[`LSS_STAT_CC_AVAIL] = cc_r;
          prdata_nxt[`LSS_STAT_DATA_EN]  = data_en_r;
        end
        else if (i_paddr == `LSS_OFF_IRQ_STAT)
          prdata_nxt[`LSS_IRQ_W-1:0] = irq_stat_r;
        else if (i_paddr == `LSS_OFF_IRQ_MASK)
          prdata_nxt[`LSS_IRQ_W-1:0] = irq_mask_r;
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_r    <= ST_LOAD;
      hold_r     <= '0;
      fmt_r      <= `LSS_FMT_DEFAULT;
      cc_r       <= 1'b0;
      data_en_r  <= 1'b0;
      lock_d_r   <= '0;
      irq_stat_r <= '0;
      irq_mask_r <= `LSS_IRQ_MASK_RST;
      prdata_r   <= '0;
      pslverr_r  <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      hold_r     <= hold_nxt;
      fmt_r      <= fmt_nxt;
      cc_r       <= cc_nxt;
      data_en_r  <= data_en_nxt;
      lock_d_r   <= lock;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      prdata_r   <= prdata_nxt;
      pslverr_r  <= pslverr_nxt;
    end
  end

  // Access phase waits until defaults are loaded
  assign o_pready   = i_psel && i_penable && loaded;
  assign o_prdata   = prdata_r;
  assign o_pslverr  = pslverr_r && o_pready;
  assign o_fmt      = fmt_r;
  assign o_cc_avail = cc_r;
  assign o_cfg_lock = lock[`LSS_LINK_CFG];
  assign o_lock     = lock[`LSS_LINK_VID];
  assign o_data_en  = data_en_r;
  assign o_irq      = |(irq_stat_r & irq_mask_r);
endmodule // lss_top

// [hw/lss_defs.svh]
// Offsets, fields, reset values and timing counts of the start-up sequencer
`ifndef LSS_DEFS_SVH
`define LSS_DEFS_SVH

`define LSS_CLK_MHZ        200
`define LSS_PWR_HOLD_US    2000
`define LSS_PWR_HOLD_CYC   (`LSS_PWR_HOLD_US * `LSS_CLK_MHZ)
`define LSS_LOCK_US        3000
`define LSS_LOCK_CYC       (`LSS_LOCK_US * `LSS_CLK_MHZ)
`define LSS_CNT_W          20
`define LSS_SYNC_CYC       2

`define LSS_ADDR_W         8
`define LSS_OFF_CTRL       8'h00
`define LSS_OFF_STAT       8'h04
`define LSS_OFF_IRQ_STAT   8'h08
`define LSS_OFF_IRQ_MASK   8'h0C

`define LSS_FMT_RATE       0
`define LSS_FMT_WIDTH      1
`define LSS_FMT_PROT       2
`define LSS_FMT_DEFAULT    3'h0

`define LSS_STAT_CFG_LOCK  3
`define LSS_STAT_VID_LOCK  4
`define LSS_STAT_CC_AVAIL  5
`define LSS_STAT_DATA_EN   6

`define LSS_IRQ_VID_LOCK   0
`define LSS_IRQ_LOCK_LOST  1
`define LSS_IRQ_CC_READY   2
`define LSS_IRQ_W          3
`define LSS_IRQ_MASK_RST   3'h0

`define LSS_LINK_CFG       0
`define LSS_LINK_VID       1

`endif

// [hw/lss_pkg.sv]
// Types of the start-up sequencer
package lss_pkg;

  typedef logic [2:0] lss_fmt_t;

  typedef enum logic [2:0]
  {
    ST_LOAD     = 3'b000,
    ST_HOLD     = 3'b001,
    ST_NO_LINK  = 3'b010,
    ST_CFG_LINK = 3'b011,
    ST_VID_LINK = 3'b100
  } lss_state_t;

endpackage

// [hw/lss_lock_if.sv]
// Qualify and lock signals between sequencer and lock detector
`timescale 1ns/10ps
interface lss_lock_if;
  logic qual;
  logic lock;
  modport det (input qual, output lock);
  modport ctl (output qual, input lock);
endinterface

// [hw/lss_sync.sv]
// Two-flop synchroniser for a vector of levels
`timescale 1ns/10ps
module lss_sync
#(
  parameter int W = 1
)
(
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_r <= '0;
      q_r    <= '0;
    end
    else
    begin
      meta_r <= i_d;
      q_r    <= meta_r;
    end
  end

  assign o_q = q_r;
endmodule // lss_sync

// [hw/lss_lock_det.sv]
// Lock detector: lock after a stable qualify period
`timescale 1ns/10ps
`include "lss_defs.svh"
module lss_lock_det
#(
  parameter int unsigned LOCK_CYC = `LSS_LOCK_CYC
)
(
  input  wire logic i_clk,
  input  wire logic i_rst,
  lss_lock_if.det   lk
);
  logic [`LSS_CNT_W-1:0] cnt_r;
  logic [`LSS_CNT_W-1:0] cnt_nxt;
  logic                  lock_r;
  logic                  lock_nxt;

  always_comb
  begin
    cnt_nxt  = cnt_r;
    lock_nxt = lock_r;
    if (!lk.qual)
    begin
      cnt_nxt  = '0;
      lock_nxt = 1'b0;
    end
    else if (!lock_r)
    begin
      if (cnt_r >= `LSS_CNT_W'(LOCK_CYC - 1))
        lock_nxt = 1'b1;
      else
        cnt_nxt = cnt_r + `LSS_CNT_W'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r  <= '0;
      lock_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      lock_r <= lock_nxt;
    end
  end

  assign lk.lock = lock_r;
endmodule // lss_lock_det

// [testbench/lss_ser_model.sv]
// Remote serializer model: link presence and stream format
`timescale 1ns/10ps
module lss_ser_model
(
  input  wire logic              i_clk,
  input  wire logic              i_cfg_en,
  input  wire logic              i_vid_en,
  input  wire lss_pkg::lss_fmt_t i_fmt,
  output logic                   o_cfg_sig,
  output logic                   o_ser_sig,
  output lss_pkg::lss_fmt_t      o_rx_fmt
);
  import lss_pkg::*;
  initial
  begin
    o_cfg_sig = 1'h0; // Unpaired inputs low
    o_ser_sig = 1'h0;
    o_rx_fmt  = 3'h0;
  end
  always @(posedge i_clk)
  begin
    o_cfg_sig <= i_cfg_en && !i_vid_en;
    o_ser_sig <= i_vid_en;
    o_rx_fmt  <= i_fmt;
  end
endmodule // lss_ser_model

// [testbench/lss_top_asserts.sv]
// Port assertions of the start-up sequencer
`timescale 1ns/10ps
`include "lss_defs.svh"
module lss_top_asserts
#(
  parameter int unsigned PWR_HOLD_CYC = 20,
  parameter int unsigned LOCK_CYC     = 10
)
(
  input wire logic                   i_clk,
  input wire logic                   i_rst,
  input wire logic                   i_psel,
  input wire logic                   i_penable,
  input wire logic                   i_pwrite,
  input wire logic [`LSS_ADDR_W-1:0] i_paddr,
  input wire logic [31:0]            i_pwdata,
  input wire logic [31:0]            o_prdata,
  input wire logic                   o_pready,
  input wire logic                   o_pslverr,
  input wire logic                   i_cfg_sig,
  input wire logic                   i_ser_sig,
  input wire lss_pkg::lss_fmt_t      i_rx_fmt,
  input wire lss_pkg::lss_fmt_t      o_fmt,
  input wire logic                   o_cc_avail,
  input wire logic                   o_cfg_lock,
  input wire logic                   o_lock,
  input wire logic                   o_data_en,
  input wire logic                   o_irq
);
  import lss_pkg::*;
  logic [19:0] cyc_r;
  logic [19:0] cyc_nxt;
  always_comb cyc_nxt = (cyc_r == 20'hFFFFF) ? cyc_r : cyc_r + 20'h1;
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst) cyc_r <= 20'h0;
    else cyc_r <= cyc_nxt;
  // Remote link already present while reset was held
  logic late_r;
  always_ff @(posedge i_clk)
    if (i_rst) late_r <= i_cfg_sig || i_ser_sig;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_cc_lock: assert property (
    o_cc_avail |-> $past(o_cfg_lock || o_lock))
    else $error("channel usable without lock");
  a_late_hold: assert property (
    late_r && cyc_r <= PWR_HOLD_CYC |-> !o_cc_avail)
    else $error("channel usable during power-up hold");
  a_early_idle: assert property (
    cyc_r <= LOCK_CYC |-> !o_cc_avail && !o_cfg_lock)
    else $error("link up too early");
  a_fmt_write: assert property (
    o_fmt != $past(o_fmt) |->
    $past(i_psel && i_penable && i_pwrite && i_paddr == `LSS_OFF_CTRL))
    else $error("format changed without write");
  a_cfg_src: assert property (
    $rose(o_cfg_lock) |-> $past(i_cfg_sig, 5))
    else $error("config lock without signal");
  a_fmt_drop: assert property (
    (o_fmt[2:1] != i_rx_fmt[2:1])[*5] |-> !o_cfg_lock && !o_lock)
    else $error("lock kept on format mismatch");
  a_data_lock: assert property (
    o_data_en |-> $past(o_lock))
    else $error("data without video lock");
  a_vid_src: assert property (
    $rose(o_lock) |-> $past(i_ser_sig, 5))
    else $error("video lock without signal");
  a_one_link: assert property (
    !(o_cfg_lock && o_lock))
    else $error("both links locked");
  a_pready_wait: assert property (
    $past(i_psel && !i_penable) && i_psel && i_penable |-> o_pready)
    else $error("access not answered");
  c_cfg: cover property ($rose(o_cfg_lock));
  c_vid: cover property ($rose(o_data_en));
  c_irq: cover property ($rose(o_irq));
endmodule // lss_top_asserts
bind lss_top lss_top_asserts #(.PWR_HOLD_CYC(PWR_HOLD_CYC),
  .LOCK_CYC(LOCK_CYC)) chk_u (.*);

// [testbench/lss_top_tb.sv]
// Self-checking bench of the start-up sequencer
`timescale 1ns/10ps
`include "lss_defs.svh"
module lss_top_tb;
  import lss_pkg::*;
  logic                   i_clk, i_rst, i_psel, i_penable, i_pwrite;
  logic [`LSS_ADDR_W-1:0] i_paddr;
  logic [31:0]            i_pwdata, o_prdata, rs, nf;
  logic                   o_pready, o_pslverr, i_cfg_sig, i_ser_sig;
  logic                   o_cc_avail, o_cfg_lock, o_lock, o_data_en, o_irq;
  logic                   cfg_en, vid_en;
  lss_fmt_t               i_rx_fmt, o_fmt, fmt;
  logic [64:0]            exp_q[$];
  logic [64:0]            ent;
  int                     errors, checked, n, b;
  lss_top #(.PWR_HOLD_CYC(20), .LOCK_CYC(10)) dut_u (.*);
  lss_ser_model ser_u (.i_clk(i_clk), .i_cfg_en(cfg_en), .i_vid_en(vid_en),
    .i_fmt(fmt), .o_cfg_sig(i_cfg_sig), .o_ser_sig(i_ser_sig),
    .o_rx_fmt(i_rx_fmt));
  initial
  begin
    i_clk = 1'h0;
    forever #2.5 i_clk = ~i_clk;
  end
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] m = 32'h0, input logic [31:0] e = 32'h0,
    input logic er = 1'h0);
    if (!w) exp_q.push_back({er, m, e});
    i_psel <= 1'h1;
    i_penable <= 1'h0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk) i_penable <= 1'h1;
    n = 0;
    do @(posedge i_clk); while (o_pready !== 1'h1 && ++n < 50);
    if (n >= 50) begin errors++; give_verdict(); end
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic wt(input int s, input logic v);
    n = 0;
    while ((s == 0 ? o_cc_avail : s == 1 ? o_cfg_lock : o_data_en) !== v
      && n < 300)
    begin
      @(posedge i_clk);
      n++;
    end
    if (n >= 300) begin errors++; give_verdict(); end
  endtask
  always @(posedge i_clk)
    if (i_psel && i_penable && o_pready && !i_pwrite && exp_q.size() > 0)
    begin
      ent = exp_q.pop_front();
      chk(o_prdata & ent[63:32], ent[31:0]);
      chk({31'h0, o_pslverr}, {31'h0, ent[64]});
    end
  initial
  begin
    {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    {cfg_en, vid_en, fmt, errors, checked} = '0;
    cfg_en = 1'h1;
    rs = 32'h0000A5DF;
    i_rst = 1'h1;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (15) @(posedge i_clk);
    apb(0, `LSS_OFF_STAT, 0, 32'h20, 32'h0);
    wt(0, 1);
    apb(0, `LSS_OFF_STAT, 0, 32'h7F, 32'h2B);
    $display("late power-up and config link done");
    apb(1, `LSS_OFF_IRQ_MASK, 32'h7);
    chk({31'h0, o_irq}, 32'h1);
    apb(1, `LSS_OFF_IRQ_STAT, 32'h7);
    chk({31'h0, o_irq}, 32'h0);
    apb(1, `LSS_OFF_IRQ_MASK, 32'h0);
    $display("interrupt done");
    b = xs() % 3;
    repeat (4)
    begin
      nf = fmt ^ (32'h1 << b);
      b = (b + 1) % 3;
      apb(1, `LSS_OFF_CTRL, nf);
      if (nf[2:1] != fmt[2:1])
      begin
        wt(1, 0);
        apb(0, `LSS_OFF_IRQ_STAT, 0, 32'h2, 32'h2);
        apb(1, `LSS_OFF_IRQ_STAT, 32'h7);
      end
      else apb(0, `LSS_OFF_STAT, 0, 32'h28, 32'h28);
      fmt <= nf[2:0];
      wt(0, 1);
      apb(0, `LSS_OFF_CTRL, 0, 32'hFFFFFFFF, nf);
      chk({29'h0, o_fmt}, nf);
    end
    $display("format pairs done");
    apb(1, `LSS_OFF_STAT, 32'hFFFFFFFF);
    apb(0, 8'h10, 0, 32'hFFFFFFFF, 32'h0, 1'h1);
    apb(0, `LSS_OFF_STAT, 0, 32'h2F, 32'h2B);
    $display("refusals done");
    vid_en <= 1'h1;
    wt(2, 1);
    apb(0, `LSS_OFF_STAT, 0, 32'h7F, 32'h74);
    chk({30'h0, o_lock, o_data_en}, 32'h3);
    apb(1, `LSS_OFF_CTRL, {29'h0, fmt ^ 3'h2});
    wt(2, 0);
    fmt <= fmt ^ 3'h2;
    wt(2, 1);
    apb(0, `LSS_OFF_STAT, 0, 32'h7F, 32'h74);
    $display("video link done");
    i_rst <= 1'h1;
    cfg_en <= 1'h0;
    vid_en <= 1'h0;
    fmt <= 3'h0;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'h0;
    repeat (5) @(posedge i_clk);
    apb(0, `LSS_OFF_STAT, 0, 32'h3F, 32'h02);
    chk({29'h0, o_cc_avail, o_cfg_lock, o_lock}, 32'h0);
    apb(0, `LSS_OFF_CTRL, 0, 32'hFFFFFFFF, 32'h0);
    cfg_en <= 1'h1;
    wt(0, 1);
    apb(0, `LSS_OFF_STAT, 0, 32'h7F, 32'h2B);
    $display("early power-up done");
    give_verdict();
  end
endmodule // lss_top_tb
